// file: design/eascal_regs.vh
// Register map, field positions and constants of the angle unit.
// Assumes a 16-bit register port with byte addresses as printed.
`ifndef EASCAL_REGS_VH
`define EASCAL_REGS_VH

// Register offsets
`define EAS_ADDR_UNIT    16'h1fc0
`define EAS_ADDR_WAVEFORM_ENABLE_A    16'h1fc1
`define EAS_ADDR_PERIOD  16'h1fc2
`define EAS_ADDR_ANGLE   16'h1fc4
`define EAS_ADDR_AMP     16'h1fc6
`define EAS_ADDR_CAPTURE 16'h1fc8
`define EAS_ADDR_SINE    16'h1fca

// Unit control bits
`define EAS_UC_DIR       7
`define EAS_UC_PHDIR     6
`define EAS_UC_CK_HI     5
`define EAS_UC_CK_LO     4
`define EAS_UC_MOD       3
`define EAS_UC_XFER      2
`define EAS_UC_WAVE      1
`define EAS_UC_TMR       0

// Waveform_enable_a control bits
`define EAS_CC_START     3
`define EAS_CC_BUSY      2
`define EAS_CC_NOSYNC    1
`define EAS_CC_ISEL      0

// Period setting fields
`define EAS_PS_CORR_HI   15
`define EAS_PS_CORR_LO   12
`define EAS_PS_PER_HI    11
`define EAS_PS_PER_LO    0

// Reset values
`define EAS_UC_RESET     8'h00
`define EAS_CC_RESET     2'h0
`define EAS_PS_RESET     16'h0010
`define EAS_ANGLE_RESET  9'h000
`define EAS_WORD_RESET   16'h0000

// Angle and timing constants
`define EAS_ANGLE_MAX    9'h17f
`define EAS_ANGLE_HALF   9'h0c0
`define EAS_ANGLE_STEPS  10'h180
`define EAS_PHASE_OFS    10'h080
`define EAS_PERIOD_MIN   12'h010
`define EAS_WAVEFORM_ENABLE_A_CYCLES  6'h23
`define EAS_PRE_SEL_MAX  2'h3

`endif

// file: design/eascal_step_timer.v
// Angle step timer: prescaler taps and corrected period counter.
// Assumes all inputs come from logic on sys_clk_i.
`timescale 1ns/1ns
`default_nettype none
`include "eascal_regs.vh"

module eascal_step_timer #(
	parameter PW    = 12,
	parameter CW    = 4,
	parameter PRE_W = 6
) (
	input  wire          sys_clk_i,
	input  wire          reset_i,
	input  wire          enable_i,
	input  wire [1:0]    clk_sel_i,
	input  wire [PW-1:0] period_i,
	input  wire [CW-1:0] corr_i,
	output wire          step_o
);

	reg  [PRE_W-1:0] pre_reg;
	reg  [PW:0]      cnt_reg;
	reg  [CW-1:0]    slot_reg;
	reg              step_reg;
	wire [PRE_W-1:0] pre_last;
	wire             pre_tick;
	wire [PW-1:0]    m_eff;
	wire             extra;
	wire [PW:0]      cnt_last;

	// Divide by 8, 16, 32 or 64
	assign pre_last = {PRE_W{1'b1}} >> (`EAS_PRE_SEL_MAX - clk_sel_i);
	assign pre_tick = (pre_reg == pre_last);
	assign m_eff    = (period_i < `EAS_PERIOD_MIN) ? `EAS_PERIOD_MIN : period_i;
	assign extra    = (slot_reg < corr_i);
	assign cnt_last = extra ? {1'b0, m_eff} : ({1'b0, m_eff} - {{PW{1'b0}}, 1'b1});
	assign step_o   = step_reg;

	always @(posedge sys_clk_i)
	begin
		if (reset_i || !enable_i)
		begin
			pre_reg  <= {PRE_W{1'b0}};
			cnt_reg  <= {(PW+1){1'b0}};
			slot_reg <= {CW{1'b0}};
			step_reg <= 1'b0;
		end
		else
		begin
			step_reg <= 1'b0;
			if (pre_tick)
			begin
				pre_reg <= {PRE_W{1'b0}};
				if (cnt_reg >= cnt_last)
				begin
					cnt_reg  <= {(PW+1){1'b0}};
					slot_reg <= slot_reg + {{(CW-1){1'b0}}, 1'b1};
					step_reg <= 1'b1;
				end
				else
					cnt_reg <= cnt_reg + {{PW{1'b0}}, 1'b1};
			end
			else
				pre_reg <= pre_reg + {{(PRE_W-1){1'b0}}, 1'b1};
		end
	end

endmodule
`default_nettype wire

// file: design/eascal_sine_ram.v
// Sine table storage in flip-flops, one write port, one read index.
// Assumes write and read indices stay below DEPTH.
`timescale 1ns/1ns
`default_nettype none

module eascal_sine_ram #(
	parameter DW    = 16,
	parameter AW    = 9,
	parameter DEPTH = 384
) (
	input  wire          sys_clk_i,
	input  wire          wr_en_i,
	input  wire [AW-1:0] wr_addr_i,
	input  wire [DW-1:0] wr_data_i,
	input  wire [AW-1:0] rd_addr_i,
	output wire [DW-1:0] rd_data_o
);

	reg [DW-1:0] mem [0:DEPTH-1];

	assign rd_data_o = mem[rd_addr_i];

	always @(posedge sys_clk_i)
	begin
		if (wr_en_i)
			mem[wr_addr_i] <= wr_data_i;
	end

endmodule
`default_nettype wire

// file: design/eascal_top.v
// Electrical angle timer and sine wave arithmetic unit.
// Assumes register port, position event and modulation period on sys_clk_i.
// Operation
// - Of 16 steps, n use period m plus one, the rest use m.
// - Period value sits in low 12 bits; values under minimum act as minimum.
// - Angle counter readable and writable while counting; values above max refused.
// - Amplitude is multiplied by the sine entry of the current angle.
// - Product is limited by the modulation period value.
// - Position detection latches the angle counter into the capture register.
// - Three-phase mode flips the sign of the sine term at half cycle.
// - Writing one to the start bit begins a calculation; zero does nothing.
// - Busy bit reads one while calculating, zero while stopped.
// - Sync bit zero starts calculations on timer steps and angle writes.
// - Interrupt select picks timer completion or end of calculation.
// - Direction bit zero counts up, one counts down.
// - Phase bit places V and W at plus or minus 120 and 240.
// - Clock select picks fc divided by 8, 16, 32 or 64.
// - Modulation bit zero selects two-phase, one selects three-phase.
// - Bits 2..0 enable transfer, calculation and timer; all reset zero.
// - One revolution lasts (m plus n/16) times 384 timer clocks.
// - Timer enable starts counting; disable stops and clears the counter.
// - Each calculation takes a fixed 35 machine cycles.
`timescale 1ns/1ns
`default_nettype none
`include "eascal_regs.vh"

module eascal_top #(
	parameter AMP_W = 16,
	parameter TBL_W = 16
) (
	input  wire        sys_clk_i,
	input  wire        reset_i,
	input  wire [15:0] addr_i,
	input  wire [15:0] wdata_i,
	input  wire        wr_i,
	input  wire        rd_i,
	output wire [15:0] rdata_o,
	input  wire        pos_detect_i,
	input  wire [15:0] modulation_period_i,
	output wire [15:0] cmp_u_o,
	output wire [15:0] cmp_v_o,
	output wire [15:0] cmp_w_o,
	output wire        cmp_load_o,
	output wire        angle_irq_o
);

	// Software registers
	reg  [7:0]       unit_control_reg;
	reg  [1:0]       waveform_enable_a_control_reg;
	reg  [15:0]      period_setting_reg;
	reg  [8:0]       angle_counter_reg;
	reg  [8:0]       angle_counter_next;
	reg  [AMP_W-1:0] amplitude_value_reg;
	reg  [8:0]       angle_capture_reg;
	reg  [15:0]      rdata_reg;
	reg  [15:0]      rdata_next;

	// Calculation state
	reg              busy_reg;
	reg  [5:0]       waveform_enable_a_cnt_reg;
	reg  [8:0]       waveform_enable_a_angle_reg;
	reg  [15:0]      res_u_reg;
	reg  [15:0]      res_v_reg;
	reg  [15:0]      res_w_reg;
	reg  [15:0]      cmp_u_reg;
	reg  [15:0]      cmp_v_reg;
	reg  [15:0]      cmp_w_reg;
	reg              cmp_load_reg;
	reg              irq_reg;
	reg              tmr_en_d_reg;

	// Decoded controls
	wire             count_direction;
	wire             phase_direction;
	wire [1:0]       timer_clock_select;
	wire             modulation_type;
	wire             result_transfer_enable;
	wire             waveform_enable_a;
	wire             angle_timer_enable;
	wire             angle_sync_waveform_enable_a_enable;
	wire             interrupt_timing_select;
	wire [11:0]      period_value;
	wire [3:0]       period_correction_count;

	assign count_direction         = unit_control_reg[`EAS_UC_DIR];
	assign phase_direction         = unit_control_reg[`EAS_UC_PHDIR];
	assign timer_clock_select      = unit_control_reg[`EAS_UC_CK_HI:`EAS_UC_CK_LO];
	assign modulation_type         = unit_control_reg[`EAS_UC_MOD];
	assign result_transfer_enable  = unit_control_reg[`EAS_UC_XFER];
	assign waveform_enable_a       = unit_control_reg[`EAS_UC_WAVE];
	assign angle_timer_enable      = unit_control_reg[`EAS_UC_TMR];
	assign angle_sync_waveform_enable_a_enable  = ~waveform_enable_a_control_reg[`EAS_CC_NOSYNC];
	assign interrupt_timing_select = waveform_enable_a_control_reg[`EAS_CC_ISEL];
	assign period_value            = period_setting_reg[`EAS_PS_PER_HI:`EAS_PS_PER_LO];
	assign period_correction_count = period_setting_reg[`EAS_PS_CORR_HI:`EAS_PS_CORR_LO];

	// Bus strobes
	wire wr_unit   = wr_i && (addr_i == `EAS_ADDR_UNIT);
	wire wr_waveform_enable_a   = wr_i && (addr_i == `EAS_ADDR_WAVEFORM_ENABLE_A);
	wire wr_period = wr_i && (addr_i == `EAS_ADDR_PERIOD);
	wire wr_angle  = wr_i && (addr_i == `EAS_ADDR_ANGLE);
	wire wr_amp    = wr_i && (addr_i == `EAS_ADDR_AMP);
	wire wr_sine   = wr_i && (addr_i == `EAS_ADDR_SINE);
	// Angle writes above the maximum are dropped whole
	wire angle_ok  = (wdata_i[15:9] == 7'h00) && (wdata_i[8:0] <= `EAS_ANGLE_MAX);
	wire angle_set = wr_angle && angle_ok;

	// Angle timer
	wire step_raw;
	wire step;

	eascal_step_timer #(
		.PW    (12),
		.CW    (4),
		.PRE_W (6)
	) u_step_timer (
		.sys_clk_i (sys_clk_i),
		.reset_i   (reset_i),
		.enable_i  (angle_timer_enable),
		.clk_sel_i (timer_clock_select),
		.period_i  (period_value),
		.corr_i    (period_correction_count),
		.step_o    (step_raw)
	);

	// A step launched on the disabling edge is dropped
	assign step = step_raw && angle_timer_enable;

	// Phase table index
	reg  [1:0]  phase_sel;
	reg  [1:0]  phase_k;
	reg  [9:0]  phase_sum;
	reg  [8:0]  phase_idx;
	wire [TBL_W-1:0] sine_rd;

	always @*
	begin
		phase_sel = waveform_enable_a_cnt_reg[1:0];
		phase_k   = phase_sel;
		if (phase_direction && (phase_sel != 2'd0))
			phase_k = 2'd3 - phase_sel;
		phase_sum = {1'b0, waveform_enable_a_angle_reg};
		if (phase_k == 2'd1)
			phase_sum = phase_sum + `EAS_PHASE_OFS;
		else if (phase_k == 2'd2)
			phase_sum = phase_sum + `EAS_PHASE_OFS + `EAS_PHASE_OFS;
		if (phase_sum >= `EAS_ANGLE_STEPS)
			phase_sum = phase_sum - `EAS_ANGLE_STEPS;
		phase_idx = phase_sum[8:0];
	end

	eascal_sine_ram #(
		.DW    (TBL_W),
		.AW    (9),
		.DEPTH (`EAS_ANGLE_STEPS)
	) u_sine_ram (
		.sys_clk_i (sys_clk_i),
		.wr_en_i   (wr_sine),
		.wr_addr_i (angle_counter_reg),
		.wr_data_i (wdata_i[TBL_W-1:0]),
		.rd_addr_i (phase_idx),
		.rd_data_o (sine_rd)
	);

	// Waveform arithmetic
	wire [TBL_W+AMP_W-1:0] product = sine_rd * amplitude_value_reg;
	wire [15:0] scaled  = product[TBL_W+AMP_W-1:TBL_W+AMP_W-16];
	wire [15:0] limited = (scaled > modulation_period_i) ? modulation_period_i : scaled;
	wire [15:0] half_md = {1'b0, modulation_period_i[15:1]};
	wire [15:0] half_lm = {1'b0, limited[15:1]};
	wire        pos_half = (phase_idx < `EAS_ANGLE_HALF);
	wire [15:0] three_ph = pos_half ? (half_md + half_lm) : (half_md - half_lm);
	wire [15:0] result   = modulation_type ? three_ph : limited;

	// Calculation starts
	wire sw_start   = wr_waveform_enable_a && wdata_i[`EAS_CC_START];
	wire auto_start = angle_sync_waveform_enable_a_enable && !busy_reg && (step || angle_set);
	wire waveform_enable_a_start = waveform_enable_a && (sw_start || auto_start);
	wire waveform_enable_a_last  = busy_reg && (waveform_enable_a_cnt_reg == (`EAS_WAVEFORM_ENABLE_A_CYCLES - 6'h01));
	// A restart in the last cycle suppresses completion
	wire waveform_enable_a_done  = waveform_enable_a_last && !waveform_enable_a_start;

	// Angle counter next value
	always @*
	begin
		angle_counter_next = angle_counter_reg;
		if (angle_set)
			angle_counter_next = wdata_i[8:0];
		else if (tmr_en_d_reg && !angle_timer_enable)
			angle_counter_next = `EAS_ANGLE_RESET;
		else if (step && !count_direction)
		begin
			if (angle_counter_reg == `EAS_ANGLE_MAX)
				angle_counter_next = `EAS_ANGLE_RESET;
			else
				angle_counter_next = angle_counter_reg + 9'h001;
		end
		else if (step)
		begin
			if (angle_counter_reg == `EAS_ANGLE_RESET)
				angle_counter_next = `EAS_ANGLE_MAX;
			else
				angle_counter_next = angle_counter_reg - 9'h001;
		end
	end

	// Register writes
	always @(posedge sys_clk_i)
	begin
		if (reset_i)
		begin
			unit_control_reg    <= `EAS_UC_RESET;
			waveform_enable_a_control_reg    <= `EAS_CC_RESET;
			period_setting_reg  <= `EAS_PS_RESET;
			angle_counter_reg   <= `EAS_ANGLE_RESET;
			amplitude_value_reg <= `EAS_WORD_RESET;
			angle_capture_reg   <= `EAS_ANGLE_RESET;
			tmr_en_d_reg        <= 1'b0;
		end
		else
		begin
			tmr_en_d_reg      <= angle_timer_enable;
			angle_counter_reg <= angle_counter_next;
			if (wr_unit)
				unit_control_reg <= wdata_i[7:0];
			if (wr_waveform_enable_a)
				waveform_enable_a_control_reg <= wdata_i[`EAS_CC_NOSYNC:`EAS_CC_ISEL];
			if (wr_period)
				period_setting_reg <= wdata_i;
			if (wr_amp)
				amplitude_value_reg <= wdata_i[AMP_W-1:0];
			if (pos_detect_i)
				angle_capture_reg <= angle_counter_reg;
		end
	end

	// Calculation sequencer
	always @(posedge sys_clk_i)
	begin
		if (reset_i)
		begin
			busy_reg       <= 1'b0;
			waveform_enable_a_cnt_reg   <= 6'h00;
			waveform_enable_a_angle_reg <= `EAS_ANGLE_RESET;
			res_u_reg      <= `EAS_WORD_RESET;
			res_v_reg      <= `EAS_WORD_RESET;
			res_w_reg      <= `EAS_WORD_RESET;
		end
		else if (!waveform_enable_a)
		begin
			busy_reg     <= 1'b0;
			waveform_enable_a_cnt_reg <= 6'h00;
		end
		else if (waveform_enable_a_start)
		begin
			busy_reg       <= 1'b1;
			waveform_enable_a_cnt_reg   <= 6'h00;
			waveform_enable_a_angle_reg <= angle_counter_next;
		end
		else if (busy_reg)
		begin
			case (waveform_enable_a_cnt_reg)
				6'h00: res_u_reg <= result;
				6'h01: res_v_reg <= result;
				6'h02: res_w_reg <= result;
				default: ;
			endcase
			if (waveform_enable_a_last)
			begin
				busy_reg     <= 1'b0;
				waveform_enable_a_cnt_reg <= 6'h00;
			end
			else
				waveform_enable_a_cnt_reg <= waveform_enable_a_cnt_reg + 6'h01;
		end
	end

	// Result transfer and interrupt request
	always @(posedge sys_clk_i)
	begin
		if (reset_i)
		begin
			cmp_u_reg    <= `EAS_WORD_RESET;
			cmp_v_reg    <= `EAS_WORD_RESET;
			cmp_w_reg    <= `EAS_WORD_RESET;
			cmp_load_reg <= 1'b0;
			irq_reg      <= 1'b0;
		end
		else
		begin
			cmp_load_reg <= 1'b0;
			if (waveform_enable_a_done && waveform_enable_a && result_transfer_enable)
			begin
				cmp_u_reg    <= res_u_reg;
				cmp_v_reg    <= res_v_reg;
				cmp_w_reg    <= res_w_reg;
				cmp_load_reg <= 1'b1;
			end
			irq_reg <= interrupt_timing_select ? (waveform_enable_a_done && waveform_enable_a) : step;
		end
	end

	// Read port
	always @*
	begin
		rdata_next = 16'h0000;
		case (addr_i)
			`EAS_ADDR_UNIT:    rdata_next = {8'h00, unit_control_reg};
			`EAS_ADDR_WAVEFORM_ENABLE_A:    rdata_next = {13'h0000, busy_reg, waveform_enable_a_control_reg};
			`EAS_ADDR_PERIOD:  rdata_next = period_setting_reg;
			`EAS_ADDR_ANGLE:   rdata_next = {7'h00, angle_counter_reg};
			`EAS_ADDR_AMP:     rdata_next = amplitude_value_reg;
			`EAS_ADDR_CAPTURE: rdata_next = {7'h00, angle_capture_reg};
			default:           rdata_next = 16'h0000;
		endcase
	end

	// Read data stands one cycle, zero otherwise
	always @(posedge sys_clk_i)
	begin
		if (reset_i)
			rdata_reg <= 16'h0000;
		else if (rd_i)
			rdata_reg <= rdata_next;
		else
			rdata_reg <= 16'h0000;
	end

	assign rdata_o     = rdata_reg;
	assign cmp_u_o     = cmp_u_reg;
	assign cmp_v_o     = cmp_v_reg;
	assign cmp_w_o     = cmp_w_reg;
	assign cmp_load_o  = cmp_load_reg;
	assign angle_irq_o = irq_reg;

endmodule
`default_nettype wire

// file: testbench/eascal_props.sv
// Port checker for the angle unit.
// Assumes binding to eascal_top on one clock.
`timescale 1ns/1ns
`default_nettype none
module eascal_props (
	input wire logic        sys_clk_i,
	input wire logic        reset_i,
	input wire logic [15:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic        wr_i,
	input wire logic        rd_i,
	input wire logic [15:0] rdata_o,
	input wire logic        pos_detect_i,
	input wire logic [15:0] modulation_period_i,
	input wire logic [15:0] cmp_u_o,
	input wire logic [15:0] cmp_v_o,
	input wire logic [15:0] cmp_w_o,
	input wire logic        cmp_load_o,
	input wire logic        angle_irq_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (reset_i);
	logic [7:0] uc_reg;
	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
			uc_reg <= 8'h00;
		else if (wr_i && addr_i == 16'h1fc0)
			uc_reg <= wdata_i[7:0];
	end
	sequence s_start;
		wr_i && addr_i == 16'h1fc1 && wdata_i[3] && uc_reg[2:1] == 2'h3;
	endsequence
	sequence s_quiet;
		(!wr_i)[*8];
	endsequence
	property p_waveform_enable_a_time;
		s_start ##1 s_quiet |-> ##28 cmp_load_o;
	endproperty
	a_waveform_enable_a_time: assert property (p_waveform_enable_a_time) else $error("result load late");
	property p_load_xfer;
		cmp_load_o |-> uc_reg[2] && uc_reg[1] ##1 !cmp_load_o;
	endproperty
	a_load_xfer: assert property (p_load_xfer) else $error("load without transfer");
	property p_irq_pulse;
		angle_irq_o |=> !angle_irq_o;
	endproperty
	a_irq_pulse: assert property (p_irq_pulse) else $error("irq too long");
	property p_cmp_hold;
		!cmp_load_o |-> $stable(cmp_u_o) && $stable(cmp_v_o) && $stable(cmp_w_o);
	endproperty
	a_cmp_hold: assert property (p_cmp_hold) else $error("compare moved");
	property p_read_cc;
		rd_i && addr_i == 16'h1fc1 |=> rdata_o[15:3] == 13'h0000;
	endproperty
	a_read_cc: assert property (p_read_cc) else $error("waveform_enable_a ctrl high bits");
	property p_read_uc;
		rd_i && addr_i == 16'h1fc0 |=> rdata_o == {8'h00, uc_reg};
	endproperty
	a_read_uc: assert property (p_read_uc) else $error("unit ctrl readback");
	property p_sine_wo;
		rd_i && addr_i == 16'h1fca |=> rdata_o == 16'h0000;
	endproperty
	a_sine_wo: assert property (p_sine_wo) else $error("sine data readable");
	property p_cmp_limit;
		cmp_load_o |-> cmp_u_o <= modulation_period_i && cmp_v_o <= modulation_period_i
			&& cmp_w_o <= modulation_period_i;
	endproperty
	a_cmp_limit: assert property (p_cmp_limit) else $error("compare above limit");
endmodule
bind eascal_top eascal_props u_props (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .addr_i(addr_i),
	.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pos_detect_i(pos_detect_i),
	.modulation_period_i(modulation_period_i), .cmp_u_o(cmp_u_o), .cmp_v_o(cmp_v_o),
	.cmp_w_o(cmp_w_o), .cmp_load_o(cmp_load_o), .angle_irq_o(angle_irq_o));
`default_nettype wire

// file: testbench/eascal_pwm_model.sv
// PWM compare registers fed by the angle unit.
// Assumes load pulses on sys_clk_i.
`timescale 1ns/1ns
`default_nettype none
module eascal_pwm_model (
	input  wire logic        sys_clk_i,
	input  wire logic        reset_i,
	input  wire logic        load_i,
	input  wire logic [15:0] u_i,
	input  wire logic [15:0] v_i,
	input  wire logic [15:0] w_i,
	output var  logic [15:0] duty_u_o,
	output var  logic [15:0] duty_v_o,
	output var  logic [15:0] duty_w_o,
	output var  logic [15:0] loads_o
);
	always @(posedge sys_clk_i)
	begin
		if (reset_i)
		begin
			duty_u_o <= 16'h0000;
			duty_v_o <= 16'h0000;
			duty_w_o <= 16'h0000;
			loads_o <= 16'h0000;
		end
		else if (load_i)
		begin
			duty_u_o <= u_i;
			duty_v_o <= v_i;
			duty_w_o <= w_i;
			loads_o <= loads_o + 16'h0001;
		end
	end
endmodule
`default_nettype wire

// file: testbench/test_electrical_angle_sine_wave_waveform_enable_a.sv
// Self-checking bench of the angle unit with a PWM partner.
// Assumes eascal_top, eascal_props and eascal_pwm_model compiled first.
`timescale 1ns/1ns
`default_nettype none
module test_electrical_angle_sine_wave_waveform_enable_a;
	logic        sys_clk_i = 1'b0;
	logic        reset_i = 1'b1;
	logic [15:0] addr_i = 16'h0000;
	logic [15:0] wdata_i = 16'h0000;
	logic        wr_i = 1'b0;
	logic        rd_i = 1'b0;
	logic        pos_detect_i = 1'b0;
	logic [15:0] md = 16'h0000;
	wire  [15:0] rdata_o, cu, cv, cw, du, dv, dw, nl;
	wire         load, irq;
	int          num_errors = 0;
	int          checks = 0;
	int          cyc = 0;
	int          tbl[384];
	logic [31:0] seed = 32'h0000002c;
	logic [15:0] got, voltage_amplitude, nb;
	logic [7:0]  uc;
	int          a, n, t;
	eascal_top uut (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pos_detect_i(pos_detect_i),
		.modulation_period_i(md), .cmp_u_o(cu), .cmp_v_o(cv), .cmp_w_o(cw),
		.cmp_load_o(load), .angle_irq_o(irq));
	eascal_pwm_model pm (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .load_i(load), .u_i(cu),
		.v_i(cv), .w_i(cw), .duty_u_o(du), .duty_v_o(dv), .duty_w_o(dw), .loads_o(nl));
	always #4 sys_clk_i = ~sys_clk_i;
	task automatic end_of_test();
		$display("errors %0d checks %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge sys_clk_i)
	begin
		cyc <= cyc + 1;
		if (cyc == 40000)
		begin
			num_errors++;
			end_of_test();
		end
	end
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic logic [15:0] expv(int i);
		longint p;
		p = (longint'(tbl[i]) * voltage_amplitude) >> 16;
		if (p > md)
			p = md;
		if (!uc[3])
			return 16'(p);
		return 16'((i < 192) ? md / 2 + p / 2 : md / 2 - p / 2);
	endfunction
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		checks++;
		if (g !== e)
		begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [15:0] ad, input logic [15:0] d);
		@(posedge sys_clk_i);
		addr_i <= ad;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge sys_clk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rdchk(input logic [15:0] ad, input logic [15:0] e);
		@(posedge sys_clk_i);
		addr_i <= ad;
		rd_i <= 1'b1;
		@(posedge sys_clk_i);
		rd_i <= 1'b0;
		#1 chk(rdata_o, e);
	endtask
	task automatic wait_sig(input bit ld, output int c);
		c = 1;
		do
		begin
			@(posedge sys_clk_i);
			#1 c++;
		end while ((ld ? load : irq) !== 1'b1 && c < 3000);
		if (c >= 3000)
		begin
			num_errors++;
			$display("wrong value at %0t: wait timed out", $time);
		end
		@(posedge sys_clk_i);
		#1;
	endtask
	initial
	begin
		repeat (10) @(posedge sys_clk_i);
		reset_i <= 1'b0;
		md <= 16'(rnd()) | 16'h0800;
		rdchk(16'h1fc0, 16'h0000);
		rdchk(16'h1fc1, 16'h0000);
		rdchk(16'h1fc2, 16'h0010);
		rdchk(16'h1fd0, 16'h0000);
		for (int i = 0; i < 384; i++)
		begin
			tbl[i] = rnd() & 32'h0000ffff;
			wr(16'h1fc4, i[15:0]);
			wr(16'h1fca, tbl[i][15:0]);
		end
		rdchk(16'h1fca, 16'h0000);
		wr(16'h1fc4, 16'h0010);
		wr(16'h1fc4, 16'h0180);
		wr(16'h1fc4, 16'h217f);
		rdchk(16'h1fc4, 16'h0010);
		@(posedge sys_clk_i);
		pos_detect_i <= 1'b1;
		@(posedge sys_clk_i);
		pos_detect_i <= 1'b0;
		rdchk(16'h1fc8, 16'h0010);
		for (int k = 0; k < 4; k++)
		begin
			uc = {1'b0, k[1], 2'b00, k[0], 3'b110};
			voltage_amplitude = 16'(rnd() >> (k * 4));
			a = rnd() % 384;
			wr(16'h1fc1, 16'h0002);
			wr(16'h1fc6, voltage_amplitude);
			wr(16'h1fc0, {8'h00, uc});
			wr(16'h1fc4, a[15:0]);
			wr(16'h1fc1, 16'h000a);
			rdchk(16'h1fc1, 16'h0006);
			wait_sig(1, t);
			rdchk(16'h1fc1, 16'h0002);
			chk(du, expv(a));
			chk(dv, expv((a + (k[1] ? 256 : 128)) % 384));
			chk(dw, expv((a + (k[1] ? 128 : 256)) % 384));
		end
		nb = nl;
		wr(16'h1fc4, 16'h0005);
		wr(16'h1fc1, 16'h0002);
		repeat (40) @(posedge sys_clk_i);
		chk(nl, nb);
		wr(16'h1fc1, 16'h0001);
		wr(16'h1fc4, 16'h0005);
		wait_sig(0, t);
		repeat (2) @(posedge sys_clk_i);
		chk(du, expv(5));
		wr(16'h1fc0, 16'h0000);
		wr(16'h1fc1, 16'h0000);
		for (int s = 0; s < 4; s++)
		begin
			wr(16'h1fc0, 16'(s << 4));
			wr(16'h1fc0, 16'(s << 4 | 1));
			wait_sig(0, t);
			wait_sig(0, t);
			chk(16'(t), 16'(128 << s));
		end
		wr(16'h1fc0, 16'h0000);
		wr(16'h1fc2, 16'h5010);
		wr(16'h1fc0, 16'h0001);
		wait_sig(0, t);
		n = 0;
		repeat (16)
		begin
			wait_sig(0, t);
			n += t;
		end
		chk(16'(n), 16'h0828);
		wr(16'h1fc0, 16'h0000);
		wr(16'h1fc2, 16'h0004);
		wr(16'h1fc0, 16'h0001);
		wait_sig(0, t);
		wait_sig(0, t);
		chk(16'(t), 16'h0080);
		wr(16'h1fc4, 16'h017f);
		wait_sig(0, t);
		rdchk(16'h1fc4, 16'h0000);
		wr(16'h1fc4, 16'h0010);
		wr(16'h1fc0, 16'h0080);
		rdchk(16'h1fc4, 16'h0000);
		wr(16'h1fc0, 16'h0081);
		wait_sig(0, t);
		rdchk(16'h1fc4, 16'h017f);
		end_of_test();
	end
endmodule
`default_nettype wire
